/* src/lpc_config_regs.sv */
// serial target and configuration registers of the light/proximity sensor
//
// Behaviour
// - The identification register reads a fixed product code in its upper nibble and revision in its lower.
// - The proximity rate register keeps a three-bit code choosing proximity measurements per second.
// - The LED current field sets emitter drive to its value times 10 mA, valid from 0 to 20.
// - The LED current field holds 2 (20 mA) after reset.
// - Codes above 20 drive the emitter at the 200 mA ceiling and never more.
// - The top two bits of the LED register report the init program revision and ignore writes.
// - While self-timed measurement runs, new LED or ambient settings wait until that mode is cycled.
// - Bit 7 of the ambient register enables continuous conversion and reads 0 after reset.
// - Offset compensation, on by default, makes each ambient measurement subtract a fresh offset.
// - The averaging field asks for two to the power of its value conversions, 1 up to 128.
// - The averaging field holds 101 (32 conversions) after reset.
// - The block answers as a serial target at seven-bit address 0010011 only.
`timescale 1ns/1ps
`default_nettype none

module lpc_config_regs (
    input  wire logic              CLOCK,          // 40 MHz system clock
    input  wire logic              RST_N,          // asynchronous reset, active low
    input  wire logic              SCL_IN,         // serial clock level
    input  wire logic              SDA_IN,         // serial data level
    output logic                   SDA_OUT,        // serial data drive value
    output logic                   SDA_OE,         // high while pulling data low
    input  wire logic              SELFTIMED_EN,   // self-timed sequencer running
    output logic [5:0]             LED_DRIVE,      // applied drive code, 10 mA steps
    output logic [2:0]             PROX_RATE,      // applied proximity rate code
    output lpc_pkg::lpc_als_t      ALS_ACTIVE,     // applied ambient parameters
    output logic [7:0]             ALS_AVG_COUNT   // conversions per ambient cycle
);
    import lpc_pkg::*;

    // ==========================================================
    // helpers
    typedef enum logic [8:0] {
        LPC_IDLE = 9'h001,
        LPC_ADDR = 9'h002,
        LPC_AACK = 9'h004,
        LPC_PTR  = 9'h008,
        LPC_PACK = 9'h010,
        LPC_WDAT = 9'h020,
        LPC_WACK = 9'h040,
        LPC_RDAT = 9'h080,
        LPC_RACK = 9'h100
    } lpc_state_t;

    // clamp keeps the emitter at its ceiling for oversize codes
    function automatic logic [5:0] led_clamp(input logic [5:0] code);
        led_clamp = (code > LPC_LED_MAX) ? LPC_LED_MAX : code;
    endfunction : led_clamp

    // power-of-two conversion count
    function automatic logic [7:0] conv_count(input logic [2:0] n);
        conv_count = LPC_CONV_ONE << n;
    endfunction : conv_count

    // read mux feeding the serial engine's read data
    function automatic logic [7:0] rd_byte(input logic [7:0] p, input logic [2:0] prox,
                                           input lpc_led_t led, input lpc_als_t als);
        case (p)
            LPC_ADDR_ID:   rd_byte = {LPC_PRODUCT_ID, LPC_REVISION_ID};
            LPC_ADDR_PROX: rd_byte = {5'h00, prox};
            LPC_ADDR_LED:  rd_byte = led;
            LPC_ADDR_ALS:  rd_byte = als;
            default:       rd_byte = LPC_UNMAPPED;
        endcase
    endfunction : rd_byte

    // ==========================================================
    // declarations
    lpc_state_t state;
    lpc_state_t next_state;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic       rw;
    logic       next_rw;
    logic       sda_oe;
    logic       next_sda_oe;
    logic       wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic [7:0] rd_now;

    logic [2:0] prox_cfg;
    logic [2:0] next_prox_cfg;
    lpc_led_t   led_cfg;
    lpc_led_t   next_led_cfg;
    lpc_als_t   als_cfg;
    lpc_als_t   next_als_cfg;
    logic [5:0] next_led_drive;
    logic [2:0] next_prox_rate;
    lpc_als_t   next_als_active;
    logic [7:0] next_avg_count;

    // ==========================================================
    // bus condition decode from previous samples
    assign scl_rise  = SCL_IN & ~scl_q;
    assign scl_fall  = ~SCL_IN & scl_q;
    assign bus_start = SCL_IN & scl_q & sda_q & ~SDA_IN;
    assign bus_stop  = SCL_IN & scl_q & ~sda_q & SDA_IN;
    assign rd_now    = rd_byte(ptr, prox_cfg, led_cfg, als_cfg);

    // serial engine next state; data shifts in on rise and changes on fall
    always_comb begin
        next_state   = state;
        next_bit_cnt = bit_cnt;
        next_shift   = shift;
        next_ptr     = ptr;
        next_rw      = rw;
        next_sda_oe  = sda_oe;
        wr_stb       = 1'b0;
        wr_addr      = ptr;
        wr_data      = shift;
        if (bus_start) begin
            next_state   = LPC_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe  = 1'b0;
        end else if (bus_stop) begin
            next_state  = LPC_IDLE;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                LPC_ADDR, LPC_PTR, LPC_WDAT: begin
                    if (scl_rise && bit_cnt != LPC_BYTE_BITS) begin
                        next_shift   = {shift[6:0], SDA_IN};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == LPC_BYTE_BITS) begin
                        next_sda_oe = 1'b1; // acknowledge by pulling low
                        if (state == LPC_ADDR) begin
                            if (shift[7:1] == LPC_DEV_ADDR) begin
                                next_rw    = shift[0];
                                next_state = LPC_AACK;
                            end else begin
                                next_sda_oe = 1'b0; // not ours: stay silent
                                next_state  = LPC_IDLE;
                            end
                        end else if (state == LPC_PTR) begin
                            next_ptr   = shift;
                            next_state = LPC_PACK;
                        end else begin
                            wr_stb     = 1'b1;
                            next_ptr   = ptr + 8'h01;
                            next_state = LPC_WACK;
                        end
                    end
                end
                LPC_AACK, LPC_PACK, LPC_WACK: begin
                    if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        next_sda_oe  = 1'b0;
                        next_state   = LPC_WDAT;
                        if (state == LPC_AACK && !rw) begin
                            next_state = LPC_PTR;
                        end else if (state == LPC_AACK) begin
                            next_shift  = rd_now;
                            next_ptr    = ptr + 8'h01;
                            next_sda_oe = ~rd_now[7];
                            next_state  = LPC_RDAT;
                        end
                    end
                end
                LPC_RDAT: begin
                    if (scl_fall) begin
                        if (bit_cnt == LPC_LAST_BIT) begin
                            next_sda_oe = 1'b0; // hand data line to host for its ack
                            next_state  = LPC_RACK;
                        end else begin
                            next_shift   = {shift[6:0], 1'b0};
                            next_sda_oe  = ~shift[6];
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end
                end
                LPC_RACK: begin
                    if (scl_rise) begin
                        next_rw = SDA_IN; // reuse: high means host declined more data
                    end else if (scl_fall) begin
                        if (!rw) begin
                            next_shift   = rd_now;
                            next_ptr     = ptr + 8'h01;
                            next_sda_oe  = ~rd_now[7];
                            next_bit_cnt = 4'h0;
                            next_state   = LPC_RDAT;
                        end else begin
                            next_state = LPC_IDLE;
                        end
                    end
                end
                LPC_IDLE: next_state = LPC_IDLE;
                default:  next_state = LPC_IDLE;
            endcase
        end
    end

    // serial engine registers
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state   <= LPC_IDLE;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
            ptr     <= 8'h00;
            rw      <= 1'b0;
            sda_oe  <= 1'b0;
            SDA_OE  <= 1'b0;
            SDA_OUT <= 1'b0;
        end else begin
            state   <= next_state;
            scl_q   <= SCL_IN;
            sda_q   <= SDA_IN;
            bit_cnt <= next_bit_cnt;
            shift   <= next_shift;
            ptr     <= next_ptr;
            rw      <= next_rw;
            sda_oe  <= next_sda_oe;
            SDA_OE  <= next_sda_oe;
            SDA_OUT <= 1'b0; // open drain: only ever pulls low
        end
    end

    // ==========================================================
    // configuration registers and applied settings
    // applied copies track the written ones only while self-timed mode is off,
    // so a running sequencer never sees a setting change under it
    always_comb begin
        next_prox_cfg   = prox_cfg;
        next_led_cfg    = led_cfg;
        next_als_cfg    = als_cfg;
        next_led_drive  = LED_DRIVE;
        next_prox_rate  = PROX_RATE;
        next_als_active = ALS_ACTIVE;
        if (wr_stb) begin
            case (wr_addr)
                LPC_ADDR_PROX: next_prox_cfg        = wr_data[2:0];
                LPC_ADDR_LED:  next_led_cfg.current = wr_data[5:0];
                LPC_ADDR_ALS:  next_als_cfg         = wr_data;
                default:       next_prox_cfg        = prox_cfg;      // read-only or unmapped
            endcase
        end
        if (!SELFTIMED_EN) begin
            next_led_drive  = led_clamp(led_cfg.current);
            next_prox_rate  = prox_cfg;
            next_als_active = als_cfg;
        end
        next_avg_count = conv_count(next_als_active.avg);
    end

    // configuration registers
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            prox_cfg      <= LPC_PROX_RATE_RST;
            led_cfg       <= '{init_program_revision: LPC_INIT_PROG, current: LPC_LED_RST};
            als_cfg       <= LPC_ALS_RST;
            LED_DRIVE     <= LPC_LED_RST;
            PROX_RATE     <= LPC_PROX_RATE_RST;
            ALS_ACTIVE    <= LPC_ALS_RST;
            ALS_AVG_COUNT <= conv_count(LPC_ALS_AVG_RST);
        end else begin
            prox_cfg      <= next_prox_cfg;
            led_cfg       <= next_led_cfg;
            als_cfg       <= next_als_cfg;
            LED_DRIVE     <= next_led_drive;
            PROX_RATE     <= next_prox_rate;
            ALS_ACTIVE    <= next_als_active;
            ALS_AVG_COUNT <= next_avg_count;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    addr_ack_a: assert property (state == LPC_ADDR && !bus_start && !bus_stop && scl_fall
        && bit_cnt == LPC_BYTE_BITS && shift[7:1] == LPC_DEV_ADDR |=> state == LPC_AACK && SDA_OE)
        else $error("own address not acknowledged");
    addr_ignore_a: assert property (state == LPC_ADDR && !bus_start && !bus_stop && scl_fall
        && bit_cnt == LPC_BYTE_BITS && shift[7:1] != LPC_DEV_ADDR |=> state == LPC_IDLE ##1 !SDA_OE)
        else $error("foreign address answered");
    id_read_a: assert property (state == LPC_AACK && !bus_start && !bus_stop && scl_fall && rw
        && ptr == LPC_ADDR_ID |=> shift == {LPC_PRODUCT_ID, LPC_REVISION_ID} && SDA_OE == ~LPC_PRODUCT_ID[3])
        else $error("identification byte wrong");
    prox_unused_a: assert property (state == LPC_AACK && !bus_start && !bus_stop && scl_fall && rw
        && ptr == LPC_ADDR_PROX |=> shift == {5'h00, $past(prox_cfg)})
        else $error("unused proximity rate bits not zero");
    init_prog_a: assert property (led_cfg.init_program_revision == LPC_INIT_PROG)
        else $error("program revision bits changed");
    led_clamp_a: assert property (!SELFTIMED_EN |=>
        LED_DRIVE == (($past(led_cfg.current) > LPC_LED_MAX) ? LPC_LED_MAX : $past(led_cfg.current)))
        else $error("emitter drive not clamped to ceiling");
    hold_run_a: assert property (SELFTIMED_EN ##1 SELFTIMED_EN |->
        $stable(LED_DRIVE) && $stable(ALS_ACTIVE) && $stable(PROX_RATE))
        else $error("setting changed while self-timed mode runs");
    als_follow_a: assert property (!SELFTIMED_EN |=> ALS_ACTIVE == $past(als_cfg))
        else $error("ambient settings not applied while idle");
    avg_count_a: assert property (ALS_AVG_COUNT == (LPC_CONV_ONE << ALS_ACTIVE.avg))
        else $error("conversion count does not match averaging field");

endmodule : lpc_config_regs

`default_nettype wire

/* src/lpc_pkg.sv */
// constants and carrier types for the light/proximity configuration register block
package lpc_pkg;

    // ==========================================================
    // serial target addressing
    localparam logic [6:0] LPC_DEV_ADDR  = 7'h13;   // fixed seven-bit target address
    localparam logic [3:0] LPC_BYTE_BITS = 4'h8;    // bits in one serial byte
    localparam logic [3:0] LPC_LAST_BIT  = 4'h7;    // index of the last data bit

    // ==========================================================
    // register pointer values
    localparam logic [7:0] LPC_ADDR_ID   = 8'h81;   // product_revision_id
    localparam logic [7:0] LPC_ADDR_PROX = 8'h82;   // proximity_rate
    localparam logic [7:0] LPC_ADDR_LED  = 8'h83;   // emitter_current
    localparam logic [7:0] LPC_ADDR_ALS  = 8'h84;   // ambient_parameters
    localparam logic [7:0] LPC_UNMAPPED  = 8'h00;   // answer for any other pointer

    // ==========================================================
    // identity values, arbitrary neutral codes
    localparam logic [3:0] LPC_PRODUCT_ID  = 4'h9;  // arbitrary value
    localparam logic [3:0] LPC_REVISION_ID = 4'h4;  // arbitrary value
    localparam logic [1:0] LPC_INIT_PROG   = 2'h3;  // init_program_revision, arbitrary value

    // ==========================================================
    // field limits and reset values
    localparam logic [5:0] LPC_LED_MAX      = 6'h14;  // code 20 = 200 mA ceiling
    localparam logic [5:0] LPC_LED_RST      = 6'h02;  // 20 mA after reset
    localparam logic [2:0] LPC_PROX_RATE_RST = 3'h0;  // proximity rate code after reset
    localparam logic [2:0] LPC_ALS_RATE_RST  = 3'h0;  // ambient rate code after reset
    localparam logic [2:0] LPC_ALS_AVG_RST   = 3'h5;  // 32 conversions after reset
    localparam logic [7:0] LPC_CONV_ONE      = 8'h01; // single conversion

    // ==========================================================
    // carrier types, laid out as the register bytes
    typedef struct packed {
        logic       cont;       // continuous ambient conversion
        logic [2:0] rate;       // ambient sample rate code
        logic       offset_en;  // automatic offset compensation
        logic [2:0] avg;        // log2 of conversions per measurement
    } lpc_als_t;

    typedef struct packed {
        logic [1:0] init_program_revision; // read-only program revision
        logic [5:0] current;               // drive code, 10 mA per step
    } lpc_led_t;

    localparam lpc_als_t LPC_ALS_RST = '{cont: 1'b0, rate: LPC_ALS_RATE_RST,
                                         offset_en: 1'b1, avg: LPC_ALS_AVG_RST};

endpackage : lpc_pkg

/* sim/lpc_host_model.sv */
// behavioural serial host that drives the configuration register block from the far side
`timescale 1ns/1ps
`default_nettype none

module lpc_host_model (
    input  wire logic clk,      // system clock, host moves on its falling edge
    output logic      scl,      // serial clock, driven by the host only
    output logic      sda_pull, // high while the host pulls data low
    input  wire logic sda       // resolved data line level
);
    import lpc_pkg::*;

    // ==========================================================
    // line phases: four cycles each, four times the one-cycle minimum the target needs
    task automatic phase();
        repeat (4) @(negedge clk);
    endtask : phase

    // start also serves as repeated start, since it first brings data high with clock low
    task automatic start();
        sda_pull = 1'b0;
        phase();
        scl = 1'b1;
        phase();
        sda_pull = 1'b1;
        phase();
        scl = 1'b0;
        phase();
    endtask : start

    task automatic stop();
        sda_pull = 1'b1;
        phase();
        scl = 1'b1;
        phase();
        sda_pull = 1'b0;
        phase();
    endtask : stop

    // data only changes while the clock is low
    task automatic bit_out(input logic b);
        sda_pull = ~b;
        phase();
        scl = 1'b1;
        phase();
        scl = 1'b0;
        phase();
    endtask : bit_out

    // sampled late in the high phase, where the target's drive has settled
    task automatic bit_in(output logic b);
        sda_pull = 1'b0;
        phase();
        scl = 1'b1;
        phase();
        b = sda;
        scl = 1'b0;
        phase();
    endtask : bit_in

    // ==========================================================
    // byte level, most significant bit first
    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_out(v[i]);
        end
        bit_in(b);
        ack = ~b;
    endtask : send_byte

    // single-byte reads only, so the host always answers with a not-acknowledge
    task automatic recv_byte(output logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            bit_in(v[i]);
        end
        bit_out(1'b1);
    endtask : recv_byte

    // addressing probe with any seven-bit address, used to check refusal
    task automatic probe(input logic [6:0] a, output logic ack);
        start();
        send_byte({a, 1'b0}, ack);
        stop();
    endtask : probe

    // ==========================================================
    // register accesses at the fixed target address
    task automatic write_reg(input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        send_byte({LPC_DEV_ADDR, 1'b0}, a0);
        send_byte(p, a1);
        send_byte(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] p, output logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        send_byte({LPC_DEV_ADDR, 1'b0}, a0);
        send_byte(p, a1);
        start();
        send_byte({LPC_DEV_ADDR, 1'b1}, a2);
        recv_byte(d);
        stop();
        ok = a0 & a1 & a2;
    endtask : read_reg

    // idle bus: both lines released and high
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
endmodule : lpc_host_model
`default_nettype wire

/* sim/tb_light_prox_config_regs.sv */
// self-checking testbench of the configuration register block with a serial host model
`timescale 1ns/1ps
`default_nettype none

module tb_light_prox_config_regs;
    import lpc_pkg::*;

    logic       CLOCK, RST_N, SELFTIMED_EN, sda_out, sda_oe, scl, host_pull;
    wire logic  sda_line;
    logic [5:0] led_drive;
    logic [2:0] prox_rate;
    lpc_als_t   als_active;
    logic [7:0] als_avg_count;
    int         mismatches, n_compared;

    // open-drain data wire with pull-up: low when either party pulls
    assign sda_line = ~((sda_oe & ~sda_out) | host_pull);

    lpc_config_regs i_lpc_config_regs (.CLOCK(CLOCK), .RST_N(RST_N), .SCL_IN(scl), .SDA_IN(sda_line),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SELFTIMED_EN(SELFTIMED_EN), .LED_DRIVE(led_drive),
        .PROX_RATE(prox_rate), .ALS_ACTIVE(als_active), .ALS_AVG_COUNT(als_avg_count));

    lpc_host_model i_lpc_host_model (.clk(CLOCK), .scl(scl), .sda_pull(host_pull), .sda(sda_line));

    // ==========================================================
    // clock, 25 ns period
    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic ok;
        i_lpc_host_model.write_reg(p, d, ok);
        chk(ok, 1);
    endtask : wr

    task automatic rdchk(input logic [7:0] p, input logic [7:0] exp);
        logic ok;
        logic [7:0] d;
        i_lpc_host_model.read_reg(p, d, ok);
        chk(ok, 1);
        chk(d, exp);
    endtask : rdchk

    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk(led_drive, LPC_LED_RST);
        chk(als_active, 8'h0d);
        chk(als_avg_count, 8'h20);
        rdchk(LPC_ADDR_ID, {LPC_PRODUCT_ID, LPC_REVISION_ID});
        rdchk(LPC_ADDR_LED, {LPC_INIT_PROG, 6'h02});
        rdchk(LPC_ADDR_ALS, 8'h0d);
    endtask : t_reset

    // unused rate bits and the identity byte must shrug off writes
    task automatic t_prox();
        wr(LPC_ADDR_ID, 8'h00);
        rdchk(LPC_ADDR_ID, {LPC_PRODUCT_ID, LPC_REVISION_ID});
        wr(LPC_ADDR_PROX, 8'hff);
        rdchk(LPC_ADDR_PROX, 8'h07);
        for (int c = 1; c <= 2; c++) begin
            wr(LPC_ADDR_PROX, 8'(c));
            chk(prox_rate, 3'(c));
        end
    endtask : t_prox

    // boundary codes around the 200 mA ceiling
    task automatic t_led();
        logic [5:0] codes [5] = '{6'h00, 6'h05, 6'h14, 6'h15, 6'h3f};
        foreach (codes[i]) begin
            wr(LPC_ADDR_LED, {2'h0, codes[i]});
            chk(led_drive, (codes[i] > 6'h14) ? 6'h14 : codes[i]);
            rdchk(LPC_ADDR_LED, {LPC_INIT_PROG, codes[i]});
        end
    endtask : t_led

    // every averaging code, with the single-bit fields toggled along the way
    task automatic t_als();
        logic [7:0] d;
        for (int a = 0; a < 8; a++) begin
            d = {a[0], a[2:0], ~a[0], a[2:0]};
            wr(LPC_ADDR_ALS, d);
            chk(als_active, d);
            chk(als_avg_count, 8'h01 << a);
            rdchk(LPC_ADDR_ALS, d);
        end
    endtask : t_als

    // only the LED byte is changed while self-timed runs; rates stay alone then
    task automatic t_selftimed();
        wr(LPC_ADDR_LED, 8'h05);
        wr(LPC_ADDR_ALS, 8'h07);
        @(negedge CLOCK);
        SELFTIMED_EN = 1'b1;
        wr(LPC_ADDR_LED, 8'h09);
        chk(led_drive, 6'h05);
        rdchk(LPC_ADDR_LED, {LPC_INIT_PROG, 6'h09});
        @(negedge CLOCK);
        SELFTIMED_EN = 1'b0;
        repeat (3) @(negedge CLOCK);
        chk(led_drive, 6'h09);
        chk(als_avg_count, 8'h80);
    endtask : t_selftimed

    // a neighbour address gets no acknowledge and the block keeps working after it
    task automatic t_badaddr();
        logic ack;
        i_lpc_host_model.probe(7'h14, ack);
        chk(ack, 0);
        i_lpc_host_model.probe(7'h12, ack);
        chk(ack, 0);
        rdchk(LPC_ADDR_PROX, 8'h02);
    endtask : t_badaddr

    // ==========================================================
    // verdict and run control
    task automatic give_verdict();
        $display("mismatches=%0d compared=%0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    // hang guard: the whole sequence needs roughly 17k cycles
    initial begin
        #(80000 * 25);
        mismatches++;
        give_verdict();
    end

    initial begin
        mismatches = 0;
        n_compared = 0;
        RST_N = 1'b0;
        SELFTIMED_EN = 1'b0;
        repeat (16) @(negedge CLOCK);
        RST_N = 1'b1;
        repeat (2) @(negedge CLOCK);
        t_reset();
        t_prox();
        t_led();
        t_als();
        t_selftimed();
        t_badaddr();
        give_verdict();
    end
endmodule : tb_light_prox_config_regs
`default_nettype wire
